// ---- pkg/bal_pkg.sv ----
// Shared types and constants of the byte arithmetic and logic unit.
// Assumes a single core clock domain; no bus-reachable registers.
package bal_pkg;

   localparam int BYTE_W = 8;
   localparam int NIB_W = 4;

   // Flag and result reset values
   localparam logic ZERO_RST = 1'h0;
   localparam logic NIBBLE_RST = 1'h0;
   localparam logic CARRY_RST = 1'h0;
   localparam logic [BYTE_W-1:0] RESULT_RST = 8'h00;

   // Operation codes
   typedef enum logic [2:0] {
      add_op = 3'h0,
      add_with_carry_op = 3'h1,
      subtract_op = 3'h2,
      subtract_with_borrow_op = 3'h3,
      and_op = 3'h4,
      or_op = 3'h5,
      xor_op = 3'h6,
      compare_op = 3'h7
   } bal_op_t;

   // Source operand selection
   typedef enum logic [2:0] {
      src_immediate = 3'h0,
      src_register = 3'h1,
      src_short_direct = 3'h2,
      src_absolute_location = 3'h3,
      src_pointer_pair = 3'h4,
      src_pointer_pair_offset = 3'h5
   } bal_src_t;

endpackage : bal_pkg

// ---- pkg/bal_dp_if.sv ----
// Datapath interface between the unit's control, source mux and arithmetic core.
// Assumes all users sit in the core clock domain; purely combinational signals.
`timescale 1ns/1ps
interface bal_dp_if;
   bal_pkg::bal_src_t src_mode;
   logic [bal_pkg::BYTE_W-1:0] imm_byte;
   logic [bal_pkg::BYTE_W-1:0] reg_byte;
   logic [bal_pkg::BYTE_W-1:0] short_byte;
   logic [bal_pkg::BYTE_W-1:0] abs_byte;
   logic [bal_pkg::BYTE_W-1:0] ptr_byte;
   logic [bal_pkg::BYTE_W-1:0] ptr_off_byte;
   logic [bal_pkg::BYTE_W-1:0] src;
   bal_pkg::bal_op_t op;
   logic [bal_pkg::BYTE_W-1:0] dst;
   logic cin;
   logic [bal_pkg::BYTE_W-1:0] res;
   logic zero;
   logic nibble;
   logic carry;
   logic arith;
   logic store;

   modport mux (
      input src_mode, imm_byte, reg_byte, short_byte, abs_byte, ptr_byte, ptr_off_byte,
      output src
   );
   modport core (
      input op, dst, src, cin,
      output res, zero, nibble, carry, arith, store
   );
endinterface : bal_dp_if

// ---- verilog/bal_src_mux.sv ----
// Source operand selector of the byte arithmetic and logic unit.
// Assumes operand bytes are already fetched by the decoder side.
`timescale 1ns/1ps
module bal_src_mux (
   bal_dp_if.mux dp
);
   always_comb begin
      case (dp.src_mode)
         bal_pkg::src_immediate: dp.src = dp.imm_byte;
         bal_pkg::src_register: dp.src = dp.reg_byte;
         bal_pkg::src_short_direct: dp.src = dp.short_byte;
         bal_pkg::src_absolute_location: dp.src = dp.abs_byte;
         bal_pkg::src_pointer_pair: dp.src = dp.ptr_byte;
         bal_pkg::src_pointer_pair_offset: dp.src = dp.ptr_off_byte;
         // Unused codes fall back to the immediate byte
         default: dp.src = dp.imm_byte;
      endcase
   end
endmodule : bal_src_mux

// ---- verilog/bal_alu_core.sv ----
// Combinational byte arithmetic and logic core.
// Assumes the carry-in is the held carry flag from the control module.
`timescale 1ns/1ps
module bal_alu_core (
   bal_dp_if.core dp
);
   localparam int W = bal_pkg::BYTE_W;
   localparam int N = bal_pkg::NIB_W;

   function automatic logic is_zero(input logic [W-1:0] v);
      is_zero = (v == 8'h00);
   endfunction : is_zero

   logic ci;
   logic [W:0] add_w;
   logic [W:0] sub_w;
   logic [N:0] add_n;
   logic [N:0] sub_n;

   always_comb begin
      ci = 1'b0;
      if (dp.op == bal_pkg::add_with_carry_op || dp.op == bal_pkg::subtract_with_borrow_op) begin
         ci = dp.cin;
      end
      add_w = {1'b0, dp.dst} + {1'b0, dp.src} + {8'h00, ci};
      sub_w = {1'b0, dp.dst} - {1'b0, dp.src} - {8'h00, ci};
      add_n = {1'b0, dp.dst[N-1:0]} + {1'b0, dp.src[N-1:0]} + {4'h0, ci};
      sub_n = {1'b0, dp.dst[N-1:0]} - {1'b0, dp.src[N-1:0]} - {4'h0, ci};
      dp.res = dp.dst;
      dp.nibble = 1'b0;
      dp.carry = 1'b0;
      dp.arith = 1'b1;
      dp.store = 1'b1;
      case (dp.op)
         bal_pkg::add_op, bal_pkg::add_with_carry_op: begin
            dp.res = add_w[W-1:0];
            dp.carry = add_w[W];
            dp.nibble = add_n[N];
         end
         bal_pkg::subtract_op, bal_pkg::subtract_with_borrow_op: begin
            dp.res = sub_w[W-1:0];
            dp.carry = sub_w[W];
            dp.nibble = sub_n[N];
         end
         bal_pkg::compare_op: begin
            // Difference only feeds the flags
            dp.res = sub_w[W-1:0];
            dp.carry = sub_w[W];
            dp.nibble = sub_n[N];
            dp.store = 1'b0;
         end
         bal_pkg::and_op: begin
            dp.res = dp.dst & dp.src;
            dp.arith = 1'b0;
         end
         bal_pkg::or_op: begin
            dp.res = dp.dst | dp.src;
            dp.arith = 1'b0;
         end
         bal_pkg::xor_op: begin
            dp.res = dp.dst ^ dp.src;
            dp.arith = 1'b0;
         end
         default: begin
            dp.arith = 1'b0;
            dp.store = 1'b0;
         end
      endcase
      dp.zero = is_zero(dp.res);
   end
endmodule : bal_alu_core

// ---- verilog/bal_alu.sv ----
// Top of the byte arithmetic and logic unit: operand select, flags, result.
// Assumes the decoder presents op, operands and destination in one cycle and
// writes the result back when result_we_q is high.
`timescale 1ns/1ps

module bal_alu (
   input logic mclk,
   input logic resetn,
   input logic ce,
   input logic op_valid,
   input bal_pkg::bal_op_t op_code,
   input bal_pkg::bal_src_t src_mode,
   input logic [7:0] dst_byte,
   input logic [7:0] imm_byte,
   input logic [7:0] reg_byte,
   input logic [7:0] short_byte,
   input logic [7:0] abs_byte,
   input logic [7:0] ptr_byte,
   input logic [7:0] ptr_off_byte,
   input logic flag_wr,
   input logic flag_wr_zero,
   input logic flag_wr_nibble,
   input logic flag_wr_carry,
   output logic [7:0] result_q,
   output logic result_we_q,
   output logic result_valid_q,
   output logic zero_flag_q,
   output logic nibble_carry_flag_q,
   output logic carry_flag_q
);

   bal_dp_if dp ();

   logic fire;
   logic [7:0] result_d;
   logic result_we_d;
   logic result_valid_d;
   logic zero_flag_d;
   logic nibble_carry_flag_d;
   logic carry_flag_d;

   assign fire = ce && op_valid;

   assign dp.src_mode = src_mode;
   assign dp.imm_byte = imm_byte;
   assign dp.reg_byte = reg_byte;
   assign dp.short_byte = short_byte;
   assign dp.abs_byte = abs_byte;
   assign dp.ptr_byte = ptr_byte;
   assign dp.ptr_off_byte = ptr_off_byte;
   assign dp.op = op_code;
   assign dp.dst = dst_byte;
   // Carry chain uses the held flag
   assign dp.cin = carry_flag_q;

   bal_src_mux u_src_mux (
      .dp(dp)
   );

   bal_alu_core u_core (
      .dp(dp)
   );

   // Next state of result and flags
   always_comb begin
      result_d = result_q;
      result_we_d = 1'b0;
      result_valid_d = 1'b0;
      zero_flag_d = zero_flag_q;
      nibble_carry_flag_d = nibble_carry_flag_q;
      carry_flag_d = carry_flag_q;
      if (op_valid) begin
         result_valid_d = 1'b1;
         result_we_d = dp.store;
         if (dp.store) begin
            result_d = dp.res;
         end
         zero_flag_d = dp.zero;
         if (dp.arith) begin
            nibble_carry_flag_d = dp.nibble;
            carry_flag_d = dp.carry;
         end
      end else if (flag_wr) begin
         // Direct flag load, only when no operation runs
         zero_flag_d = flag_wr_zero;
         nibble_carry_flag_d = flag_wr_nibble;
         carry_flag_d = flag_wr_carry;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         result_q <= bal_pkg::RESULT_RST;
         result_we_q <= 1'b0;
         result_valid_q <= 1'b0;
         zero_flag_q <= bal_pkg::ZERO_RST;
         nibble_carry_flag_q <= bal_pkg::NIBBLE_RST;
         carry_flag_q <= bal_pkg::CARRY_RST;
      end else if (ce) begin
         result_q <= result_d;
         result_we_q <= result_we_d;
         result_valid_q <= result_valid_d;
         zero_flag_q <= zero_flag_d;
         nibble_carry_flag_q <= nibble_carry_flag_d;
         carry_flag_q <= carry_flag_d;
      end
   end

   a_add_sum_carry: assert property (
      @(posedge mclk) disable iff (!resetn)
      fire && op_code == bal_pkg::add_op |=>
      {carry_flag_q, result_q} == $past({1'b0, dst_byte}) + $past({1'b0, dp.src})
   ) else $error("byte add sum or carry wrong");

   a_add_zero_flag: assert property (
      @(posedge mclk) disable iff (!resetn)
      fire && (op_code == bal_pkg::add_op || op_code == bal_pkg::add_with_carry_op) |=>
      zero_flag_q == (result_q == 8'h00) && result_we_q
   ) else $error("add zero flag wrong");

   a_add_nibble_carry: assert property (
      @(posedge mclk) disable iff (!resetn)
      fire && (op_code == bal_pkg::add_op || op_code == bal_pkg::add_with_carry_op) |=>
      nibble_carry_flag_q == (result_q[4] ^ $past(dst_byte[4]) ^ $past(dp.src[4]))
   ) else $error("add nibble carry wrong");

   a_add_carry_chain: assert property (
      @(posedge mclk) disable iff (!resetn)
      fire && op_code == bal_pkg::add_with_carry_op |=>
      {carry_flag_q, result_q} ==
      $past({1'b0, dst_byte}) + $past({1'b0, dp.src}) + {8'h00, $past(carry_flag_q)}
   ) else $error("add with carry ignores old carry");

   a_sub_difference: assert property (
      @(posedge mclk) disable iff (!resetn)
      fire && op_code == bal_pkg::subtract_op |=>
      result_q == 8'($past(dst_byte) - $past(dp.src)) && result_we_q
   ) else $error("subtract difference wrong");

   a_sub_borrow: assert property (
      @(posedge mclk) disable iff (!resetn)
      fire && op_code == bal_pkg::subtract_op |=>
      carry_flag_q == ($past(dst_byte) < $past(dp.src))
   ) else $error("subtract borrow wrong");

   a_sub_nibble_borrow: assert property (
      @(posedge mclk) disable iff (!resetn)
      fire && (op_code == bal_pkg::subtract_op ||
               op_code == bal_pkg::subtract_with_borrow_op) |=>
      nibble_carry_flag_q == (result_q[4] ^ $past(dst_byte[4]) ^ $past(dp.src[4]))
   ) else $error("subtract nibble borrow wrong");

   a_sub_zero_flag: assert property (
      @(posedge mclk) disable iff (!resetn)
      fire && (op_code == bal_pkg::subtract_op ||
               op_code == bal_pkg::subtract_with_borrow_op) |=>
      zero_flag_q == (result_q == 8'h00)
   ) else $error("subtract zero flag wrong");

   a_sub_borrow_chain: assert property (
      @(posedge mclk) disable iff (!resetn)
      fire && op_code == bal_pkg::subtract_with_borrow_op |=>
      {carry_flag_q, result_q} ==
      $past({1'b0, dst_byte}) - $past({1'b0, dp.src}) - {8'h00, $past(carry_flag_q)}
   ) else $error("subtract with borrow wrong");

   a_and_keeps_flags: assert property (
      @(posedge mclk) disable iff (!resetn)
      fire && op_code == bal_pkg::and_op |=>
      result_q == ($past(dst_byte) & $past(dp.src)) &&
      $stable(nibble_carry_flag_q) && $stable(carry_flag_q)
   ) else $error("and result or flags wrong");

   a_or_keeps_flags: assert property (
      @(posedge mclk) disable iff (!resetn)
      fire && op_code == bal_pkg::or_op |=>
      result_q == ($past(dst_byte) | $past(dp.src)) &&
      $stable(nibble_carry_flag_q) && $stable(carry_flag_q)
   ) else $error("or result or flags wrong");

   a_xor_keeps_flags: assert property (
      @(posedge mclk) disable iff (!resetn)
      fire && op_code == bal_pkg::xor_op |=>
      result_q == ($past(dst_byte) ^ $past(dp.src)) &&
      $stable(nibble_carry_flag_q) && $stable(carry_flag_q)
   ) else $error("xor result or flags wrong");

   a_logic_zero_flag: assert property (
      @(posedge mclk) disable iff (!resetn)
      fire && (op_code == bal_pkg::and_op || op_code == bal_pkg::or_op ||
               op_code == bal_pkg::xor_op) |=>
      zero_flag_q == (result_q == 8'h00)
   ) else $error("logic zero flag wrong");

   a_compare_flags: assert property (
      @(posedge mclk) disable iff (!resetn)
      fire && op_code == bal_pkg::compare_op |=>
      carry_flag_q == ($past(dst_byte) < $past(dp.src)) &&
      zero_flag_q == ($past(dst_byte) == $past(dp.src))
   ) else $error("compare flags wrong");

   a_compare_no_store: assert property (
      @(posedge mclk) disable iff (!resetn)
      fire && op_code == bal_pkg::compare_op |=> !result_we_q && $stable(result_q)
   ) else $error("compare wrote the destination");

   a_idle_flags_hold: assert property (
      @(posedge mclk) disable iff (!resetn)
      !fire && !(ce && flag_wr) |=>
      $stable(zero_flag_q) && $stable(nibble_carry_flag_q) && $stable(carry_flag_q)
   ) else $error("flags moved without cause");

   a_src_pointer_sel: assert property (
      @(posedge mclk) disable iff (!resetn)
      src_mode == bal_pkg::src_pointer_pair_offset |-> dp.src == ptr_off_byte
   ) else $error("pointer offset source not selected");

   a_src_absolute_sel: assert property (
      @(posedge mclk) disable iff (!resetn)
      src_mode == bal_pkg::src_absolute_location |-> dp.src == abs_byte
   ) else $error("absolute source not selected");

   a_result_next_cycle: assert property (
      @(posedge mclk) disable iff (!resetn)
      fire |=> result_valid_q ##1 (!$past(fire) || result_valid_q || !ce)
   ) else $error("result not ready next cycle");

   a_no_spurious_valid: assert property (
      @(posedge mclk) disable iff (!resetn)
      ce && !op_valid |=> !result_valid_q && !result_we_q
   ) else $error("valid without an operation");

endmodule : bal_alu

// ---- testbench/bal_alu_bench.sv ----
// Self-checking bench for the byte arithmetic and logic unit top.
// Assumes one 10 MHz core clock; the bench drives every input at the falling edge.
`timescale 1ns/1ps
module bal_alu_bench;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic ce = 1'b1;
   logic op_valid = 1'b0;
   logic flag_wr = 1'b0;
   logic fz = 1'b0;
   logic fn = 1'b0;
   logic fc = 1'b0;
   bal_pkg::bal_op_t op_code = bal_pkg::add_op;
   bal_pkg::bal_src_t src_mode = bal_pkg::src_immediate;
   logic [7:0] dst_byte = 8'h00;
   logic [7:0] imm_byte = 8'h00;
   logic [7:0] reg_byte = 8'h22;
   logic [7:0] short_byte = 8'h33;
   logic [7:0] abs_byte = 8'h44;
   logic [7:0] ptr_byte = 8'h55;
   logic [7:0] ptr_off_byte = 8'h66;
   logic [7:0] result_q;
   logic result_we_q;
   logic result_valid_q;
   logic zero_flag_q;
   logic nibble_carry_flag_q;
   logic carry_flag_q;
   logic [12:0] obs;
   logic [12:0] snap;
   int miscompares = 0;
   int n_tests = 0;

   assign obs = {result_q, result_we_q, result_valid_q, zero_flag_q, nibble_carry_flag_q,
      carry_flag_q};

   always #50 mclk = ~mclk;

   bal_alu u_dut (
      .mclk(mclk), .resetn(resetn), .ce(ce), .op_valid(op_valid), .op_code(op_code),
      .src_mode(src_mode), .dst_byte(dst_byte), .imm_byte(imm_byte), .reg_byte(reg_byte),
      .short_byte(short_byte), .abs_byte(abs_byte), .ptr_byte(ptr_byte),
      .ptr_off_byte(ptr_off_byte), .flag_wr(flag_wr), .flag_wr_zero(fz),
      .flag_wr_nibble(fn), .flag_wr_carry(fc), .result_q(result_q),
      .result_we_q(result_we_q), .result_valid_q(result_valid_q),
      .zero_flag_q(zero_flag_q), .nibble_carry_flag_q(nibble_carry_flag_q),
      .carry_flag_q(carry_flag_q)
   );

   task check(input logic [12:0] seen, input logic [12:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task end_sim;
      $display("comparisons %0d, miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim

   // Entered at a falling edge; checks the outputs one cycle later
   task run(input bal_pkg::bal_op_t op, input logic [7:0] d, input logic [7:0] s,
      input logic [7:0] er, input logic we, input logic z, input logic n, input logic c);
      op_code = op;
      dst_byte = d;
      imm_byte = s;
      op_valid = 1'b1;
      @(posedge mclk);
      @(negedge mclk);
      check(obs, {er, we, 1'b1, z, n, c});
   endtask : run

   task idle;
      op_valid = 1'b0;
      @(posedge mclk);
      @(negedge mclk);
      check({11'h000, result_we_q, result_valid_q}, 13'h0000);
   endtask : idle

   task load_flags(input logic z, input logic n, input logic c);
      // Flag load only lands in a cycle without an operation
      op_valid = 1'b0;
      flag_wr = 1'b1;
      fz = z;
      fn = n;
      fc = c;
      @(posedge mclk);
      @(negedge mclk);
      flag_wr = 1'b0;
      check({10'h000, obs[2:0]}, {10'h000, z, n, c});
   endtask : load_flags

   task t_add;
      run(bal_pkg::add_op, 8'h0F, 8'h01, 8'h10, 1'b1, 1'b0, 1'b1, 1'b0);
      run(bal_pkg::add_op, 8'hFF, 8'h01, 8'h00, 1'b1, 1'b1, 1'b1, 1'b1);
      run(bal_pkg::add_op, 8'h80, 8'h80, 8'h00, 1'b1, 1'b1, 1'b0, 1'b1);
      run(bal_pkg::add_op, 8'h12, 8'h34, 8'h46, 1'b1, 1'b0, 1'b0, 1'b0);
      idle();
   endtask : t_add

   task t_add_chain;
      run(bal_pkg::add_op, 8'hF0, 8'h20, 8'h10, 1'b1, 1'b0, 1'b0, 1'b1);
      run(bal_pkg::add_with_carry_op, 8'h0F, 8'h00, 8'h10, 1'b1, 1'b0, 1'b1, 1'b0);
      run(bal_pkg::add_with_carry_op, 8'hFF, 8'hFF, 8'hFE, 1'b1, 1'b0, 1'b1, 1'b1);
      run(bal_pkg::add_with_carry_op, 8'h00, 8'h00, 8'h01, 1'b1, 1'b0, 1'b0, 1'b0);
      idle();
   endtask : t_add_chain

   task t_sub;
      run(bal_pkg::subtract_op, 8'h5A, 8'h5A, 8'h00, 1'b1, 1'b1, 1'b0, 1'b0);
      run(bal_pkg::subtract_op, 8'h10, 8'h01, 8'h0F, 1'b1, 1'b0, 1'b1, 1'b0);
      run(bal_pkg::subtract_op, 8'h85, 8'h03, 8'h82, 1'b1, 1'b0, 1'b0, 1'b0);
      run(bal_pkg::subtract_op, 8'h00, 8'h01, 8'hFF, 1'b1, 1'b0, 1'b1, 1'b1);
      run(bal_pkg::subtract_with_borrow_op, 8'h05, 8'h02, 8'h02, 1'b1, 1'b0, 1'b0, 1'b0);
      run(bal_pkg::subtract_with_borrow_op, 8'h05, 8'h02, 8'h03, 1'b1, 1'b0, 1'b0, 1'b0);
      run(bal_pkg::subtract_op, 8'h20, 8'h21, 8'hFF, 1'b1, 1'b0, 1'b1, 1'b1);
      run(bal_pkg::subtract_with_borrow_op, 8'h01, 8'h00, 8'h00, 1'b1, 1'b1, 1'b0, 1'b0);
      idle();
   endtask : t_sub

   task t_logic;
      load_flags(1'b0, 1'b1, 1'b1);
      run(bal_pkg::and_op, 8'h3C, 8'h0F, 8'h0C, 1'b1, 1'b0, 1'b1, 1'b1);
      run(bal_pkg::or_op, 8'h00, 8'h00, 8'h00, 1'b1, 1'b1, 1'b1, 1'b1);
      run(bal_pkg::or_op, 8'h50, 8'h0A, 8'h5A, 1'b1, 1'b0, 1'b1, 1'b1);
      load_flags(1'b1, 1'b0, 1'b0);
      run(bal_pkg::xor_op, 8'hA5, 8'hFF, 8'h5A, 1'b1, 1'b0, 1'b0, 1'b0);
      // Flag load raised together with an operation must lose
      flag_wr = 1'b1;
      fz = 1'b0;
      fn = 1'b1;
      fc = 1'b1;
      run(bal_pkg::and_op, 8'hF0, 8'h0F, 8'h00, 1'b1, 1'b1, 1'b0, 1'b0);
      flag_wr = 1'b0;
      run(bal_pkg::xor_op, 8'h66, 8'h66, 8'h00, 1'b1, 1'b1, 1'b0, 1'b0);
      idle();
   endtask : t_logic

   task t_compare;
      run(bal_pkg::add_op, 8'h00, 8'h42, 8'h42, 1'b1, 1'b0, 1'b0, 1'b0);
      run(bal_pkg::compare_op, 8'h30, 8'h31, 8'h42, 1'b0, 1'b0, 1'b1, 1'b1);
      run(bal_pkg::compare_op, 8'h77, 8'h77, 8'h42, 1'b0, 1'b1, 1'b0, 1'b0);
      run(bal_pkg::compare_op, 8'h91, 8'h10, 8'h42, 1'b0, 1'b0, 1'b0, 1'b0);
      idle();
   endtask : t_compare

   task t_sources;
      logic [7:0] tbl [8];
      tbl = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h11, 8'h11};
      for (int m = 0; m < 8; m++) begin
         src_mode = bal_pkg::bal_src_t'(m[2:0]);
         run(bal_pkg::add_op, 8'h00, 8'h11, tbl[m], 1'b1, 1'b0, 1'b0, 1'b0);
      end
      src_mode = bal_pkg::src_immediate;
      idle();
   endtask : t_sources

   task t_enable;
      run(bal_pkg::add_op, 8'h01, 8'h01, 8'h02, 1'b1, 1'b0, 1'b0, 1'b0);
      snap = obs;
      ce = 1'b0;
      dst_byte = 8'h10;
      imm_byte = 8'h10;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      check(obs, snap);
      ce = 1'b1;
      run(bal_pkg::add_op, 8'h10, 8'h10, 8'h20, 1'b1, 1'b0, 1'b0, 1'b0);
      idle();
   endtask : t_enable

   // Mid-run reset clears result and flags
   task t_reset;
      resetn = 1'b0;
      @(posedge mclk);
      @(negedge mclk);
      check(obs, 13'h0000);
      resetn = 1'b1;
      idle();
   endtask : t_reset

   // Watchdog against a hung sequence
   initial begin
      repeat (5000) @(posedge mclk);
      miscompares++;
      end_sim();
   end

   initial begin
      repeat (4) @(negedge mclk);
      resetn = 1'b1;
      check(obs, 13'h0000);
      t_add();
      t_add_chain();
      t_sub();
      t_logic();
      t_compare();
      t_sources();
      t_enable();
      t_reset();
      end_sim();
   end
endmodule : bal_alu_bench
